// ### hw/tafq_pkg.sv
// Purpose: shared constants and types of the temperature alarm block
// Assumes: 9-bit resolution variant, 20 MHz system clock
// Notes:   register select codes follow the pointer register encoding
package tafq_pkg;

  // register select codes
  localparam logic [1:0] SEL_TEMP  = 2'h0;
  localparam logic [1:0] SEL_CFG   = 2'h1;
  localparam logic [1:0] SEL_LOWER = 2'h2;
  localparam logic [1:0] SEL_UPPER = 2'h3;

  // nine-bit left-justified field in every 16-bit value register
  localparam int LIM_MSB = 15;
  localparam int LIM_LSB = 7;
  localparam int LIM_W   = LIM_MSB - LIM_LSB + 1;
  localparam logic [LIM_LSB-1:0] LIM_PAD = 7'h00;

  // power-up values
  localparam logic [15:0] UPPER_RST  = 16'h5000;
  localparam logic [15:0] LOWER_RST  = 16'h4B00;
  localparam logic [15:0] TEMP_BLANK = 16'h8000;
  localparam logic [4:0]  CFG_RST    = 5'h00;

  // configuration fields
  localparam int CFG_SHDN_BIT  = 0;
  localparam int CFG_INT_BIT   = 1;
  localparam int CFG_POL_BIT   = 2;
  localparam int CFG_DEPTH_LSB = 3;
  localparam int CFG_DEPTH_MSB = 4;
  localparam int CFG_W         = 5;
  localparam logic [2:0] CFG_RSVD_ZERO = 3'h0;

  // fault queue depth codes and the count each selects
  localparam logic [1:0] DEPTH_CODE_1 = 2'h0;
  localparam logic [1:0] DEPTH_CODE_2 = 2'h1;
  localparam logic [1:0] DEPTH_CODE_4 = 2'h2;
  localparam logic [1:0] DEPTH_CODE_6 = 2'h3;
  localparam logic [2:0] DEPTH_1      = 3'h1;
  localparam logic [2:0] DEPTH_2      = 3'h2;
  localparam logic [2:0] DEPTH_4      = 3'h4;
  localparam logic [2:0] DEPTH_6      = 3'h6;
  localparam logic [2:0] CNT_ZERO     = 3'h0;
  localparam logic [2:0] CNT_ONE      = 3'h1;

  // conversion timing
  localparam int CLK_HZ           = 20_000_000;
  localparam int CONV_TIME_MS     = 133;
  localparam int CONV_CYCLES_DFLT = (CLK_HZ / 1000) * CONV_TIME_MS;
  localparam int CONV_CNT_W       = 22;
  localparam logic [CONV_CNT_W-1:0] CONV_CNT_ZERO = 22'h00_0000;
  localparam logic [CONV_CNT_W-1:0] CONV_CNT_ONE  = 22'h00_0001;

  // fault tracker states
  typedef enum logic [3:0] {
    FQ_WATCH_HIGH = 4'h1,
    FQ_ALARM_HIGH = 4'h2,
    FQ_WATCH_LOW  = 4'h4,
    FQ_ALARM_LOW  = 4'h8
  } tafq_state_t;

endpackage

// ### hw/tafq_fq_if.sv
// Purpose: carrier between the register side and the fault tracker
// Assumes: all signals synchronous to sys_clk
// Notes:   no clocking; both ends sit in the same domain
`timescale 1ns/1ps
interface tafq_fq_if;
  logic       sample;
  logic       above;
  logic       below;
  logic       clear;
  logic       int_mode;
  logic [2:0] depth;
  logic       host_read;
  logic       fault;

  modport ctl (output sample, output above, output below, output clear,
               output int_mode, output depth, output host_read, input fault);
  modport fq  (input sample, input above, input below, input clear,
               input int_mode, input depth, input host_read, output fault);
endinterface

// ### hw/tafq_fault_queue.sv
// Purpose: consecutive-reading fault queue and alarm state
// Assumes: sample is a one-cycle pulse per completed conversion
// Notes:   fault is polarity free; the pin polarity is applied by the top
`timescale 1ns/1ps
module tafq_fault_queue
  import tafq_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_sync_b,
  tafq_fq_if.fq     fq
);

  tafq_state_t state_r;
  tafq_state_t state_nxt;
  logic [2:0]  cnt_r;
  logic [2:0]  cnt_nxt;
  logic        hit;
  logic [2:0]  cnt_inc;

  assign fq.fault = (state_r == FQ_ALARM_HIGH) || (state_r == FQ_ALARM_LOW);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    hit       = 1'b0;
    cnt_inc   = cnt_r + CNT_ONE;
    if (fq.clear) begin
      // clearing also returns interrupt mode to watching the upper limit
      state_nxt = FQ_WATCH_HIGH;
      cnt_nxt   = CNT_ZERO;
    end else begin
      case (state_r)
        FQ_WATCH_HIGH: hit = fq.above;
        FQ_ALARM_HIGH: hit = !fq.int_mode && fq.below;
        FQ_WATCH_LOW:  hit = fq.below;
        FQ_ALARM_LOW:  hit = 1'b0;
        default:       hit = 1'b0;
      endcase
      if (fq.int_mode && fq.host_read && fq.fault) begin
        // any register read ends a latched interrupt and flips the watch
        state_nxt = (state_r == FQ_ALARM_HIGH) ? FQ_WATCH_LOW : FQ_WATCH_HIGH;
        cnt_nxt   = CNT_ZERO;
      end else if (fq.sample) begin
        if (!hit) begin
          cnt_nxt = CNT_ZERO;
        end else if (cnt_inc == fq.depth) begin
          cnt_nxt = CNT_ZERO;
          case (state_r)
            FQ_WATCH_HIGH: state_nxt = FQ_ALARM_HIGH;
            FQ_ALARM_HIGH: state_nxt = FQ_WATCH_HIGH;
            FQ_WATCH_LOW:  state_nxt = FQ_ALARM_LOW;
            default:       state_nxt = FQ_WATCH_HIGH;
          endcase
        end else begin
          cnt_nxt = cnt_inc;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_r <= FQ_WATCH_HIGH;
      cnt_r   <= CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

endmodule

// ### hw/tafq_top.sv
// Purpose: alarm, limit and result register logic of a temperature sensor
// Assumes: a serial slave front end decodes address and pointer and gives
//          one-cycle read, write and stop strobes; adc_code is the converter
//          output, valid when a conversion period ends
// Notes:   9-bit resolution; the result keeps bits 15 to 7 only
`timescale 1ns/1ps
module tafq_top
  import tafq_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DFLT
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [1:0]  reg_sel,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  input  wire logic        bus_stop,
  input  wire logic [15:0] adc_code,
  output logic [15:0]      reg_rdata,
  output logic             conv_active,
  output logic             alarm_output
);

  localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);

  // reset release synchroniser
  logic rst_meta_r;
  logic rst_sync_b;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  tafq_fq_if fq_bus ();

  // register state
  logic [LIM_W-1:0]  upper_r;
  logic [LIM_W-1:0]  upper_nxt;
  logic [LIM_W-1:0]  lower_r;
  logic [LIM_W-1:0]  lower_nxt;
  logic [CFG_W-1:0]  cfg_r;
  logic [CFG_W-1:0]  cfg_nxt;
  logic [LIM_W-1:0]  temp_r;
  logic [LIM_W-1:0]  temp_nxt;
  logic              temp_blank_r;
  logic              temp_blank_nxt;
  logic [15:0]       rdata_r;
  logic [15:0]       rdata_nxt;

  // conversion state
  logic [CONV_CNT_W-1:0] conv_cnt_r;
  logic [CONV_CNT_W-1:0] conv_cnt_nxt;
  logic                  hold_r;
  logic                  hold_nxt;
  logic                  conv_done;
  logic                  running;

  // alarm pin
  logic alarm_r;
  logic alarm_nxt;

  logic             shutdown;
  logic             wr_clears;
  logic [LIM_W-1:0] code9;
  logic [15:0]      temp_view;
  logic [15:0]      rd_mux;

  assign shutdown  = cfg_r[CFG_SHDN_BIT];
  assign code9     = adc_code[LIM_MSB:LIM_LSB];
  assign wr_clears = reg_wr && (reg_sel != SEL_TEMP);
  assign running   = !shutdown && !hold_r;
  assign conv_done = running && (conv_cnt_r == CONV_LAST);

  // result as the host sees it; blank from the shutdown write onward, not one
  // cycle later, and until a fresh conversion lands after leaving shutdown
  assign temp_view = (temp_blank_r || shutdown) ? TEMP_BLANK
                                                : {temp_r, LIM_PAD};

  always_comb begin
    case (reg_sel)
      SEL_TEMP:  rd_mux = temp_view;
      SEL_CFG:   rd_mux = {8'h00, CFG_RSVD_ZERO, cfg_r};
      SEL_LOWER: rd_mux = {lower_r, LIM_PAD};
      SEL_UPPER: rd_mux = {upper_r, LIM_PAD};
      default:   rd_mux = 16'h0000;
    endcase
  end

  // host register writes and read capture
  always_comb begin
    upper_nxt = upper_r;
    lower_nxt = lower_r;
    cfg_nxt   = cfg_r;
    rdata_nxt = rdata_r;
    if (reg_wr) begin
      case (reg_sel)
        SEL_UPPER: upper_nxt = reg_wdata[LIM_MSB:LIM_LSB];
        SEL_LOWER: lower_nxt = reg_wdata[LIM_MSB:LIM_LSB];
        SEL_CFG:   cfg_nxt   = reg_wdata[CFG_W-1:0];
        default:   cfg_nxt   = cfg_r;
      endcase
    end
    if (reg_rd) begin
      rdata_nxt = rd_mux;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      upper_r <= UPPER_RST[LIM_MSB:LIM_LSB];
      lower_r <= LOWER_RST[LIM_MSB:LIM_LSB];
      cfg_r   <= CFG_RST;
      rdata_r <= 16'h0000;
    end else begin
      upper_r <= upper_nxt;
      lower_r <= lower_nxt;
      cfg_r   <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // conversion timer, abort on result read, resume on stop
  always_comb begin
    conv_cnt_nxt   = conv_cnt_r;
    hold_nxt       = hold_r;
    temp_nxt       = temp_r;
    temp_blank_nxt = temp_blank_r;
    if (shutdown) begin
      conv_cnt_nxt   = CONV_CNT_ZERO;
      temp_blank_nxt = 1'b1;
    end else if (conv_done) begin
      conv_cnt_nxt   = CONV_CNT_ZERO;
      temp_nxt       = code9;
      temp_blank_nxt = 1'b0;
    end else if (running) begin
      conv_cnt_nxt = conv_cnt_r + CONV_CNT_ONE;
    end
    // a result read wins over a conversion ending in the same cycle,
    // so the value the host just captured is not replaced mid-transaction
    if (reg_rd && (reg_sel == SEL_TEMP) && !shutdown) begin
      hold_nxt     = 1'b1;
      conv_cnt_nxt = CONV_CNT_ZERO;
      if (conv_done) begin
        temp_nxt       = temp_r;
        temp_blank_nxt = temp_blank_r;
      end
    end else if (bus_stop) begin
      hold_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      conv_cnt_r   <= CONV_CNT_ZERO;
      hold_r       <= 1'b0;
      temp_r       <= TEMP_BLANK[LIM_MSB:LIM_LSB];
      temp_blank_r <= 1'b1;
    end else begin
      conv_cnt_r   <= conv_cnt_nxt;
      hold_r       <= hold_nxt;
      temp_r       <= temp_nxt;
      temp_blank_r <= temp_blank_nxt;
    end
  end

  // fault tracker hookup; the sample is the fresh code, not the old result
  logic               take_sample;
  logic [2:0]         depth_sel;

  always_comb begin
    case (cfg_r[CFG_DEPTH_MSB:CFG_DEPTH_LSB])
      DEPTH_CODE_1: depth_sel = DEPTH_1;
      DEPTH_CODE_2: depth_sel = DEPTH_2;
      DEPTH_CODE_4: depth_sel = DEPTH_4;
      DEPTH_CODE_6: depth_sel = DEPTH_6;
      default:      depth_sel = DEPTH_1;
    endcase
  end

  // an aborted conversion produces no sample
  assign take_sample = conv_done && !(reg_rd && (reg_sel == SEL_TEMP));

  assign fq_bus.sample    = take_sample;
  assign fq_bus.above     = $signed(code9) > $signed(upper_r);
  assign fq_bus.below     = $signed(code9) < $signed(lower_r);
  assign fq_bus.clear     = shutdown || wr_clears;
  assign fq_bus.int_mode  = cfg_r[CFG_INT_BIT];
  assign fq_bus.depth     = depth_sel;
  assign fq_bus.host_read = reg_rd;

  tafq_fault_queue u_fault_queue (
    .sys_clk    (sys_clk),
    .rst_sync_b (rst_sync_b),
    .fq         (fq_bus)
  );

  // polarity applied only here, after the tracker
  always_comb begin
    alarm_nxt = cfg_r[CFG_POL_BIT] ? fq_bus.fault : !fq_bus.fault;
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      alarm_r <= 1'b1;
    end else begin
      alarm_r <= alarm_nxt;
    end
  end

  // conv_active from a flop so the pin stays glitch free
  logic conv_active_r;

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      conv_active_r <= 1'b0;
    end else begin
      conv_active_r <= !shutdown && !hold_nxt;
    end
  end

  assign reg_rdata    = rdata_r;
  assign conv_active  = conv_active_r;
  assign alarm_output = alarm_r;

endmodule

// ### test/tafq_props.sv
// Purpose: port checks of the temperature alarm block
// Assumes: one-cycle host strobes
// Notes:   polarity and shutdown are shadowed from config writes
`timescale 1ns/1ps
module tafq_props
  import tafq_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic [1:0]  reg_sel,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_rd,
  input wire logic        bus_stop,
  input wire logic [15:0] adc_code,
  input wire logic [15:0] reg_rdata,
  input wire logic        conv_active,
  input wire logic        alarm_output
);
  logic cfg_wr;
  logic pol_r;
  logic pol_nxt;
  logic sd_r;
  logic sd_nxt;
  always_comb begin
    cfg_wr  = reg_wr && reg_sel == SEL_CFG;
    pol_nxt = cfg_wr ? reg_wdata[CFG_POL_BIT] : pol_r;
    sd_nxt  = cfg_wr ? reg_wdata[CFG_SHDN_BIT] : sd_r;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pol_r <= 1'b0;
      sd_r  <= 1'b0;
    end else begin
      pol_r <= pol_nxt;
      sd_r  <= sd_nxt;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_rd_pad; reg_rd && reg_sel != SEL_CFG |=> reg_rdata[6:0] == LIM_PAD; endproperty
  a_rd_pad: assert property (p_rd_pad) else $error("pad bits set");
  property p_cfg_pad; reg_rd && reg_sel == SEL_CFG |=> reg_rdata[15:5] == 11'h000; endproperty
  a_cfg_pad: assert property (p_cfg_pad) else $error("config pad set");
  property p_temp_hold; reg_rd && reg_sel == SEL_TEMP |=> !conv_active; endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("no hold");
  property p_resume; bus_stop && !reg_rd && !sd_r |=> conv_active; endproperty
  a_resume: assert property (p_resume) else $error("no resume");
  property p_wr_clear; reg_wr && reg_sel != SEL_TEMP |=> ##1 alarm_output == !pol_r; endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("write left alarm");
  property p_shdn_blank; reg_rd && reg_sel == SEL_TEMP && sd_r |=> reg_rdata == 16'h8000; endproperty
  a_shdn_blank: assert property (p_shdn_blank) else $error("result not blank");
  property p_shdn_idle; sd_r |=> !conv_active; endproperty
  a_shdn_idle: assert property (p_shdn_idle) else $error("converting in shutdown");
  property p_shdn_alarm; sd_r |=> alarm_output == !pol_r; endproperty
  a_shdn_alarm: assert property (p_shdn_alarm) else $error("alarm in shutdown");
endmodule
bind tafq_top tafq_props i_tafq_props (
  .sys_clk, .rst_b, .reg_sel, .reg_wr, .reg_wdata, .reg_rd,
  .bus_stop, .adc_code, .reg_rdata, .conv_active, .alarm_output
);

// ### test/tafq_host.sv
// Purpose: host model issuing register strobes
// Assumes: requests launched at the falling edge
// Notes:   released data is inverted so stale values never look valid
`timescale 1ns/1ps
module tafq_host
  import tafq_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [15:0] reg_rdata,
  output logic [1:0]       reg_sel,
  output logic             reg_wr,
  output logic [15:0]      reg_wdata,
  output logic             reg_rd,
  output logic             bus_stop
);
  initial begin
    reg_sel   = SEL_TEMP;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd    = 1'b0;
    bus_stop  = 1'b0;
  end
  // shutdown is entered by a config write with bit 0 high
  task automatic wr(input logic [1:0] sel, input logic [15:0] v);
    @(negedge sys_clk);
    reg_sel   = sel;
    reg_wdata = v;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~v;
  endtask
  task automatic rd(input logic [1:0] sel, output logic [15:0] v);
    @(negedge sys_clk);
    reg_sel = sel;
    reg_rd  = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    v      = reg_rdata;
  endtask
  task automatic stop();
    @(negedge sys_clk);
    bus_stop = 1'b1;
    @(negedge sys_clk);
    bus_stop = 1'b0;
  endtask
endmodule

// ### test/tafq_top_tb.sv
// Purpose: self-checking bench of the temperature alarm block
// Assumes: short conversion period
// Notes:   each test restarts conversions so sample counts are exact
`timescale 1ns/1ps
module tafq_top_tb;
  import tafq_pkg::*;
  localparam int CONV = 16;
  typedef struct {
    logic [4:0]  cfg;
    logic [15:0] adc;
    int          n;
    logic        alarm;
  } tafq_row_t;
  logic        sys_clk;
  logic        rst_b;
  logic [1:0]  reg_sel;
  logic        reg_wr;
  logic [15:0] reg_wdata;
  logic        reg_rd;
  logic        bus_stop;
  logic [15:0] adc_code;
  logic [15:0] reg_rdata;
  logic        conv_active;
  logic        alarm_output;
  logic [15:0] d;
  int          failures = 0;
  int          checks_done = 0;
  tafq_row_t   rows [10] = '{
    '{5'h04, 16'h5080, 1, 1'b1}, '{5'h04, 16'h507F, 2, 1'b0},
    '{5'h0C, 16'h5080, 1, 1'b0}, '{5'h0C, 16'h5080, 2, 1'b1},
    '{5'h14, 16'h5080, 3, 1'b0}, '{5'h14, 16'h5080, 4, 1'b1},
    '{5'h1C, 16'h5080, 5, 1'b0}, '{5'h1C, 16'h5080, 6, 1'b1},
    '{5'h00, 16'h5080, 1, 1'b0}, '{5'h00, 16'hE700, 2, 1'b1}
  };
  tafq_top #(.CONV_CYCLES(CONV)) i_tafq_top (
    .sys_clk, .rst_b, .reg_sel, .reg_wr, .reg_wdata, .reg_rd, .bus_stop,
    .adc_code, .reg_rdata, .conv_active, .alarm_output
  );
  tafq_host i_tafq_host (
    .sys_clk, .reg_rdata, .reg_sel, .reg_wr, .reg_wdata, .reg_rd, .bus_stop
  );
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chka(input logic e);
    chk("alarm_output", {15'h0000, alarm_output}, {15'h0000, e});
  endtask
  task automatic rchk(input logic [1:0] sel, input logic [15:0] exp);
    i_tafq_host.rd(sel, d);
    chk("reg_rdata", d, exp);
  endtask
  task automatic set_cfg(input logic [15:0] v);
    i_tafq_host.wr(SEL_CFG, v);
  endtask
  // a temp read plus stop restarts the timer, then sit mid-period
  task automatic sync();
    i_tafq_host.rd(SEL_TEMP, d);
    i_tafq_host.stop();
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic conv(input logic [15:0] a, input int n);
    adc_code = a;
    repeat (CONV * n) @(negedge sys_clk);
  endtask
  task automatic ack();
    i_tafq_host.rd(SEL_UPPER, d);
    repeat (2) @(negedge sys_clk);
    chka(1'b0);
    sync();
  endtask
  // cut a hang at about six times the expected run
  initial begin
    repeat (8000) @(posedge sys_clk);
    failures++;
    complete_run();
  end
  initial begin
    rst_b    = 1'b0;
    adc_code = 16'h0000;
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge sys_clk);
    chka(1'b1);
    rchk(SEL_TEMP, 16'h8000);
    rchk(SEL_UPPER, 16'h5000);
    rchk(SEL_LOWER, 16'h4B00);
    rchk(SEL_CFG, 16'h0000);
    foreach (rows[i]) begin
      set_cfg({11'h000, rows[i].cfg});
      sync();
      conv(rows[i].adc, rows[i].n);
      chka(rows[i].alarm);
      rchk(SEL_TEMP, rows[i].adc & 16'hFF80);
    end
    set_cfg(16'h0004);
    sync();
    chk("conv_active", {15'h0000, conv_active}, 16'h0001);
    conv(16'h5080, 1);
    conv(16'h4B00, 2);
    chka(1'b1);
    conv(16'h4A80, 1);
    chka(1'b0);
    set_cfg(16'h0014);
    sync();
    conv(16'h5080, 3);
    conv(16'h4D00, 1);
    conv(16'h5080, 3);
    chka(1'b0);
    conv(16'h5080, 1);
    chka(1'b1);
    set_cfg(16'h0014);
    sync();
    conv(16'h5080, 2);
    i_tafq_host.wr(SEL_LOWER, 16'h4B00);
    conv(16'h5080, 2);
    chka(1'b0);
    conv(16'h5080, 2);
    chka(1'b1);
    i_tafq_host.wr(SEL_UPPER, 16'h5000);
    repeat (2) @(negedge sys_clk);
    chka(1'b0);
    set_cfg(16'h0006);
    sync();
    conv(16'h4A80, 2);
    chka(1'b0);
    conv(16'h5080, 2);
    chka(1'b1);
    ack();
    conv(16'h5080, 2);
    chka(1'b0);
    conv(16'h4A80, 1);
    chka(1'b1);
    ack();
    conv(16'h5080, 1);
    chka(1'b1);
    ack();
    set_cfg(16'h0006);
    sync();
    conv(16'h4A80, 1);
    chka(1'b0);
    set_cfg(16'h0005);
    rchk(SEL_TEMP, 16'h8000);
    chk("conv_active", {15'h0000, conv_active}, 16'h0000);
    conv(16'h5080, 3);
    chka(1'b0);
    set_cfg(16'h0004);
    rchk(SEL_TEMP, 16'h8000);
    sync();
    conv(16'h5080, 1);
    rchk(SEL_TEMP, 16'h5080);
    set_cfg(16'h00FF);
    rchk(SEL_CFG, 16'h001F);
    i_tafq_host.wr(SEL_UPPER, 16'h64FF);
    rchk(SEL_UPPER, 16'h6480);
    i_tafq_host.wr(SEL_LOWER, 16'h817F);
    rchk(SEL_LOWER, 16'h8100);
    // mid-run reset after the limits and config were changed
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge sys_clk);
    chka(1'b1);
    rchk(SEL_UPPER, 16'h5000);
    rchk(SEL_LOWER, 16'h4B00);
    rchk(SEL_CFG, 16'h0000);
    rchk(SEL_TEMP, 16'h8000);
    complete_run();
  end
endmodule
